// [design/encoder_scaling_defines.vh]
`ifndef ENCODER_SCALING_DEFINES_VH
`define ENCODER_SCALING_DEFINES_VH

// ==========================================
// register byte offsets
`define OFS_OPT        8'h00
`define OFS_UNITS      8'h04
`define OFS_TOTAL      8'h08
`define OFS_LOWER      8'h0c
`define OFS_UPPER      8'h10
`define OFS_PHYS       8'h14
`define OFS_CTRL       8'h18
`define OFS_STATUS     8'h1c
`define OFS_POS        8'h20
`define OFS_NV_UNITS   8'h24
`define OFS_NV_TOTAL   8'h28
`define OFS_NV_PHYS    8'h2c
`define OFS_NV_BASIS   8'h30

// ==========================================
// option byte fields
`define OPT_BASIS_LO   0
`define OPT_BASIS_HI   1
`define OPT_COMM       2
`define OPT_SHORT_DIAG 3
`define OPT_LOW_EN     5
`define OPT_UP_EN      6

// ==========================================
// control and status fields
`define CTRL_ACCEPT    0
`define CTRL_CLASS1    1
`define CTRL_STOP      2
`define ST_PARAM_ERR   0
`define ST_EXCHANGE    1
`define ST_COMM        2
`define ST_DIAG_LSB    8
`define ST_DIAG_MSB    14

// ==========================================
// process word fields
`define PW_POS_BITS    25
`define PW_READY       25
`define PW_NORMAL      26
`define PW_WINDOW      27

// ==========================================
// constants and reset values
`define DIAG_FULL      7'h39
`define DIAG_SHORT     7'h10
`define MT_REV_BITS    12
`define RST_UNITS      32'h00002000
// largest total that still passes the range check with the reset units,
// so a fresh stored set can enter exchange in commissioning mode
`define RST_TOTAL      32'h01ffffff
`define RST_PHYS       32'h00002000
`define RST_OPT        8'h00
`define CLK_HZ         20000000
`define BLINK_MS       500
`define BLINK_CYCLES   (`CLK_HZ / 1000 * `BLINK_MS)

`endif

// [design/long_divider.v]
`timescale 1ns/1ps
// restoring divider, one quotient bit per clock
module long_divider #(
  parameter NW = 64,
  parameter DW = 32
) (
  // clock and reset
  input  wire          clock,
  input  wire          nrst,
  // request
  input  wire          start,
  input  wire [NW-1:0] num,
  input  wire [DW-1:0] den,
  // result
  output reg           done_r,
  output reg  [NW-1:0] quo_r,
  output reg  [DW-1:0] rem_r
);

  localparam [6:0] NW_CNT = NW;

  reg  [6:0]  cnt_r;
  reg         busy_r;
  reg  [DW:0] part_r;
  wire [DW:0] trial;
  wire [DW:0] shifted;

  assign shifted = {part_r[DW-1:0], quo_r[NW-1]};
  assign trial   = shifted - {1'b0, den};

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r  <= 7'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      part_r <= {(DW+1){1'b0}};
      quo_r  <= {NW{1'b0}};
      rem_r  <= {DW{1'b0}};
    end
    else
    begin
      done_r <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r  <= NW_CNT;
        part_r <= {(DW+1){1'b0}};
        quo_r  <= num;
      end
      else if (busy_r)
      begin
        // zero divisor gives all ones only if num fits in DW bits; stored values rewritten during commissioning exchange skip the parameter check
        if (!trial[DW])
        begin
          part_r <= trial;
          quo_r  <= {quo_r[NW-2:0], 1'b1};
        end
        else
        begin
          part_r <= shifted;
          quo_r  <= {quo_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          rem_r  <= trial[DW] ? shifted[DW-1:0] : trial[DW-1:0];
        end
      end
    end
  end

endmodule // long_divider

// [design/encoder_scaling.v]
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "encoder_scaling_defines.vh"
// How it works
// - total below units times physical revolutions
// - scaled position wraps to zero at total
// - per revolution: units steps per turn
// - max range: units over 4096 turns
// - physical basis: units per programmed impulse count
// - basis from option bits 0 and 1
// - commissioning uses stored parameters, ignores bus set
// - commissioning allows parameter writes during exchange
// - diagnostics 57 bytes, 16 when short
// - class 1 always gives 16 diagnostic bytes
// - process bit 27 set inside limit window
// - option bits 5, 6 enable lower, upper
// - limits are 32-bit words, msb byte first
// - green indicator flashes during exchange in commissioning mode
// - input word bit 26 low in commissioning
// - 25-bit position, 3 status bits above, top 4 bits zero
module encoder_scaling #(
  parameter SPR_BITS     = 13,
  parameter BLINK_CYCLES = `BLINK_CYCLES
) (
  // clock and reset
  input  wire                         clock,
  input  wire                         nrst,
  // apb slave
  input  wire                         psel,
  input  wire                         penable,
  input  wire                         pwrite,
  input  wire [7:0]                   paddr,
  input  wire [31:0]                  pwdata,
  output reg                          pready,
  output reg  [31:0]                  prdata,
  output reg                          pslverr,
  // physical disk position, turns above steps
  input  wire [SPR_BITS+11:0]         disk_pos,
  // outputs toward the link and the base
  output reg  [31:0]                  process_word,
  output reg                          exchange_r,
  output reg                          param_err_r,
  output reg  [6:0]                   diag_len_r,
  output reg                          led_green_r
);

  localparam RAW_W = SPR_BITS + `MT_REV_BITS;
  localparam S_IDLE = 2'd0;
  localparam S_DIV1 = 2'd1;
  localparam S_DIV2 = 2'd2;
  localparam S_WAIT = 2'd3;

  // ==========================================
  // configuration registers
  reg  [7:0]  opt_r;
  reg  [31:0] units_r;
  reg  [31:0] total_r;
  reg  [31:0] lower_r;
  reg  [31:0] upper_r;
  reg  [31:0] phys_r;
  reg         class1_r;
  reg  [31:0] nv_units_r;
  reg  [31:0] nv_total_r;
  reg  [31:0] nv_phys_r;
  reg  [1:0]  nv_basis_r;
  reg  [1:0]  state_r;
  reg         start_r;
  reg  [63:0] num_r;
  reg  [31:0] den_r;
  reg  [31:0] blink_r;
  wire        div_done;
  wire [63:0] div_quo;
  wire [31:0] div_rem;

  wire comm = opt_r[`OPT_COMM];
  wire acc  = psel && penable && pready;
  wire wr   = acc && pwrite;
  wire cfg_wr_ok = !exchange_r;
  wire nv_wr_ok  = exchange_r && comm;

  // ==========================================
  // effective parameter set
  wire [31:0] eff_units = comm ? nv_units_r : units_r;
  wire [31:0] eff_total = comm ? nv_total_r : total_r;
  wire [31:0] eff_phys  = comm ? nv_phys_r  : phys_r;
  wire [1:0]  eff_basis = comm ? nv_basis_r : {opt_r[`OPT_BASIS_HI], opt_r[`OPT_BASIS_LO]};
  reg  [31:0] basis_den;

  always @*
  begin
    // per revolution and max range use fixed disk resolution
    case (eff_basis)
      2'b00:   basis_den = 32'h1 << SPR_BITS;
      2'b01:   basis_den = 32'h1 << RAW_W;
      2'b10:   basis_den = eff_phys;
      default: basis_den = eff_phys;
    endcase
  end

  // total must stay below units per turn times the physical turns
  wire [43:0] range_cap = {eff_units, 12'h000};
  wire        check_bad = ({12'h000, eff_total} >= range_cap)
                       || (eff_total == 32'h0) || (basis_den == 32'h0)
                       || (eff_units == 32'h0);

  // ==========================================
  // apb register access
  wire unmapped = (paddr[1:0] != 2'b00) || (paddr > `OFS_NV_BASIS);
  wire cfg_addr = (paddr <= `OFS_PHYS);
  wire nv_addr  = (paddr >= `OFS_NV_UNITS) && (paddr <= `OFS_NV_BASIS);
  wire bad_wr   = pwrite && ((cfg_addr && !cfg_wr_ok) || (nv_addr && !nv_wr_ok)
                             || paddr == `OFS_STATUS || paddr == `OFS_POS);
  reg  [31:0] rd_mux;

  always @*
  begin
    case (paddr)
      `OFS_OPT:      rd_mux = {24'h000000, opt_r};
      `OFS_UNITS:    rd_mux = units_r;
      `OFS_TOTAL:    rd_mux = total_r;
      `OFS_LOWER:    rd_mux = lower_r;
      `OFS_UPPER:    rd_mux = upper_r;
      `OFS_PHYS:     rd_mux = phys_r;
      `OFS_CTRL:     rd_mux = {30'h00000000, class1_r, 1'b0};
      `OFS_STATUS:   rd_mux = {17'h00000, diag_len_r, 5'h00, comm, exchange_r, param_err_r};
      `OFS_POS:      rd_mux = process_word;
      `OFS_NV_UNITS: rd_mux = nv_units_r;
      `OFS_NV_TOTAL: rd_mux = nv_total_r;
      `OFS_NV_PHYS:  rd_mux = nv_phys_r;
      `OFS_NV_BASIS: rd_mux = {30'h00000000, nv_basis_r};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      // one wait-free access phase after every setup cycle
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite && !unmapped) ? rd_mux : 32'h00000000;
      pslverr <= psel && !penable && (unmapped || bad_wr);
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      opt_r       <= `RST_OPT;
      units_r     <= `RST_UNITS;
      total_r     <= `RST_TOTAL;
      lower_r     <= 32'h00000000;
      upper_r     <= 32'h00000000;
      phys_r      <= `RST_PHYS;
      class1_r    <= 1'b0;
      nv_units_r  <= `RST_UNITS;
      nv_total_r  <= `RST_TOTAL;
      nv_phys_r   <= `RST_PHYS;
      nv_basis_r  <= 2'b00;
      exchange_r  <= 1'b0;
      param_err_r <= 1'b0;
    end
    else if (wr && !pslverr)
    begin
      case (paddr)
        `OFS_OPT:      opt_r      <= pwdata[7:0];
        `OFS_UNITS:    units_r    <= pwdata;
        `OFS_TOTAL:    total_r    <= pwdata;
        `OFS_LOWER:    lower_r    <= pwdata;
        `OFS_UPPER:    upper_r    <= pwdata;
        `OFS_PHYS:     phys_r     <= pwdata;
        `OFS_NV_UNITS: nv_units_r <= pwdata;
        `OFS_NV_TOTAL: nv_total_r <= pwdata;
        `OFS_NV_PHYS:  nv_phys_r  <= pwdata;
        `OFS_NV_BASIS: nv_basis_r <= pwdata[1:0];
        `OFS_CTRL:
        begin
          class1_r <= pwdata[`CTRL_CLASS1];
          if (pwdata[`CTRL_STOP])
            exchange_r <= 1'b0;
          else if (pwdata[`CTRL_ACCEPT])
          begin
            // a refused set keeps the slave out of cyclic exchange
            param_err_r <= check_bad;
            exchange_r  <= !check_bad;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // scaling sequencer: raw*units/basis, then wrap at total
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= S_IDLE;
      start_r <= 1'b0;
      num_r   <= 64'h0000000000000000;
      den_r   <= 32'h00000000;
    end
    else
    begin
      start_r <= 1'b0;
      case (state_r)
        S_IDLE:
          if (exchange_r)
          begin
            num_r   <= {{(64-RAW_W){1'b0}}, disk_pos} * {32'h00000000, eff_units};
            den_r   <= basis_den;
            start_r <= 1'b1;
            state_r <= S_DIV1;
          end
        S_DIV1:
          if (div_done)
          begin
            num_r   <= div_quo;
            den_r   <= eff_total;
            start_r <= 1'b1;
            state_r <= S_DIV2;
          end
        S_DIV2:
          if (div_done)
            state_r <= S_WAIT;
        S_WAIT:
          state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  long_divider #(
    .NW (64),
    .DW (32)
  ) u_div (
    .clock  (clock),
    .nrst   (nrst),
    .start  (start_r),
    .num    (num_r),
    .den    (den_r),
    .done_r (div_done),
    .quo_r  (div_quo),
    .rem_r  (div_rem)
  );

  // ==========================================
  // process word and limit window
  wire [31:0] pos_new  = div_rem;
  wire        low_ok   = !opt_r[`OPT_LOW_EN] || (pos_new >= lower_r);
  wire        up_ok    = !opt_r[`OPT_UP_EN]  || (pos_new <= upper_r);

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      process_word <= 32'h00000000;
    else if (!exchange_r)
      process_word <= {4'h0, 1'b0, !comm, 1'b0, 25'h0000000};
    else if (state_r == S_DIV2 && div_done)
    begin
      // higher position bits are overwritten by status, so totals beyond 25 bits alias
      process_word[`PW_POS_BITS-1:0] <= pos_new[`PW_POS_BITS-1:0];
      process_word[`PW_READY]        <= 1'b1;
      process_word[`PW_NORMAL]       <= !comm;
      process_word[`PW_WINDOW]       <= low_ok && up_ok;
      process_word[31:28]            <= 4'h0;
    end
    else
      process_word[`PW_NORMAL] <= !comm;
  end

  // ==========================================
  // diagnostic length and indicator
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      diag_len_r  <= `DIAG_FULL;
      blink_r     <= 32'h00000000;
      led_green_r <= 1'b0;
    end
    else
    begin
      diag_len_r <= (class1_r || opt_r[`OPT_SHORT_DIAG]) ? `DIAG_SHORT : `DIAG_FULL;
      if (blink_r >= BLINK_CYCLES - 1)
        blink_r <= 32'h00000000;
      else
        blink_r <= blink_r + 32'h00000001;
      if (exchange_r && comm)
      begin
        if (blink_r >= BLINK_CYCLES - 1)
          led_green_r <= !led_green_r;
      end
      else
        led_green_r <= exchange_r;
    end
  end

endmodule // encoder_scaling

// [tb/encoder_scaling_asserts.sv]
`timescale 1ns/1ps
// ====================
// port checker
module encoder_scaling_asserts (
  // clock and reset
  input logic        clock,
  input logic        nrst,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // link side
  input logic [31:0] process_word,
  input logic        exchange_r,
  input logic        param_err_r,
  input logic [6:0]  diag_len_r,
  input logic        led_green_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [7:0] a);
    psel && !penable && pwrite && paddr == a;
  endsequence
  // an accept with stop clear must settle into exactly one of run or error
  sequence s_accept;
    s_wr(8'h18) ##0 pwdata[2:0] == 3'b001;
  endsequence
  property p_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("access cycle wrong");
  property p_err_excl;
    param_err_r |-> !exchange_r;
  endproperty
  a_err_excl: assert property (p_err_excl) else $error("error with exchange");
  property p_accept;
    s_accept |=> ##[1:3] exchange_r != param_err_r;
  endproperty
  a_accept: assert property (p_accept) else $error("accept not settled");
  property p_top0;
    process_word[31:28] == 4'h0;
  endproperty
  a_top0: assert property (p_top0) else $error("upper bits set");
  property p_diag;
    diag_len_r == 7'h39 || diag_len_r == 7'h10;
  endproperty
  a_diag: assert property (p_diag) else $error("diag length");
  property p_led;
    !exchange_r && !$past(exchange_r) |-> !led_green_r;
  endproperty
  a_led: assert property (p_led) else $error("led lit idle");
  property p_lock;
    s_wr(8'h00) ##0 exchange_r |=> pready && pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("edit in exchange");
  property p_nv_lock;
    s_wr(8'h28) ##0 !exchange_r |=> pready && pslverr;
  endproperty
  a_nv_lock: assert property (p_nv_lock) else $error("store write");
  property p_quiet;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus not quiet");
endmodule // encoder_scaling_asserts

bind encoder_scaling encoder_scaling_asserts u_chk (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .process_word(process_word), .exchange_r(exchange_r), .param_err_r(param_err_r), .diag_len_r(diag_len_r),
  .led_green_r(led_green_r));

// [tb/disk_model.sv]
`timescale 1ns/1ps
// ====================
// encoder disk, turns above steps
module disk_model (
  // clock and reset
  input  logic        clock,
  input  logic        nrst,
  // shaft position
  input  logic [11:0] turns,
  input  logic [12:0] steps,
  // raw count
  output logic [24:0] disk_pos
);
  always @(posedge clock or negedge nrst)
    if (!nrst)
      disk_pos <= 25'h0;
    else
      disk_pos <= {turns, steps};
endmodule // disk_model

// [tb/encoder_scaling_tb_top.sv]
`timescale 1ns/1ps
// ====================
// bench top
module encoder_scaling_tb_top;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, ev;
  logic        exchange_r, param_err_r, led_green_r;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, process_word, rv;
  logic [11:0] turns;
  logic [12:0] steps;
  logic [24:0] disk_pos;
  logic [6:0]  diag_len_r;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  encoder_scaling #(.SPR_BITS(13), .BLINK_CYCLES(8)) uut (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .disk_pos(disk_pos), .process_word(process_word), .exchange_r(exchange_r),
    .param_err_r(param_err_r), .diag_len_r(diag_len_r), .led_green_r(led_green_r));
  disk_model disk (.clock(clock), .nrst(nrst), .turns(turns), .steps(steps), .disk_pos(disk_pos));

  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task automatic complete_run;
  begin
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // ====================
  // apb master, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      chk("apb answer", 32'h0, 32'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    // idle cycle so no strobe is driven twice in one step
    @(posedge clock);
  end
  endtask

  // stop first: the set is locked while exchange runs
  task automatic run(input logic [7:0] o, input logic [31:0] u, t, p, lo, up, c, st, pw,
                     input logic [11:0] tn, input logic [12:0] sp);
  begin
    turns <= tn;
    steps <= sp;
    apb(1, 8'h18, 32'h4);
    apb(1, 8'h00, {24'h0, o});
    apb(1, 8'h04, u);
    apb(1, 8'h08, t);
    apb(1, 8'h0c, lo);
    apb(1, 8'h10, up);
    apb(1, 8'h14, p);
    apb(1, 8'h18, c);
    repeat (300) @(posedge clock);
    apb(0, 8'h1c, 32'h0);
    chk("status", rv, st);
    chk("exchange", {31'h0, exchange_r}, {31'h0, st[1]});
    chk("param error", {31'h0, param_err_r}, {31'h0, st[0]});
    if (st[1])
    begin
      apb(0, 8'h20, 32'h0);
      chk("position", rv, pw);
    end
  end
  endtask

  // ====================
  // main sequence
  initial
  begin
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h0;
    pwdata = 32'h0;
    turns = 12'h0;
    steps = 13'h0;
    repeat (20) @(posedge clock);
    nrst <= 1;
    repeat (2) @(posedge clock);
    chk("idle word", process_word, 32'h04000000);
    chk("diag length", {25'h0, diag_len_r}, 32'h39);
    run(8'h00, 100, 12800, 12288, 0, 0, 1, 32'h3902, 32'h0e00015e, 3, 4096);
    run(8'h00, 100, 12800, 12288, 0, 0, 1, 32'h3902, 32'h0e0000c8, 130, 0);
    run(8'h00, 100, 409599, 12288, 0, 0, 1, 32'h3902, 32'h0e00015e, 3, 4096);
    run(8'h00, 100, 409600, 12288, 0, 0, 1, 32'h3901, 32'h0, 3, 4096);
    run(8'h01, 8192, 8192, 12288, 0, 0, 1, 32'h3902, 32'h0e000007, 3, 4096);
    run(8'h62, 400, 1000, 12288, 700, 900, 1, 32'h3902, 32'h0e000320, 3, 0);
    run(8'h62, 400, 1000, 12288, 801, 900, 1, 32'h3902, 32'h06000320, 3, 0);
    run(8'h42, 400, 1000, 12288, 801, 799, 1, 32'h3902, 32'h06000320, 3, 0);
    run(8'h22, 400, 1000, 12288, 700, 799, 1, 32'h3902, 32'h0e000320, 3, 0);
    run(8'h08, 100, 12800, 12288, 0, 0, 1, 32'h1002, 32'h0e00015e, 3, 4096);
    run(8'h00, 100, 12800, 12288, 0, 0, 3, 32'h1002, 32'h0e00015e, 3, 4096);
    // stored defaults leave the raw count unscaled, so the bus set is seen to be ignored
    run(8'h04, 100, 12800, 12288, 0, 0, 1, 32'h3906, 32'h0a007000, 3, 4096);
    chk("mode bit", {31'h0, process_word[26]}, 32'h0);
    ev = led_green_r;
    repeat (8) @(posedge clock);
    chk("led blink", {31'h0, led_green_r}, {31'h0, !ev});
    apb(1, 8'h28, 32'd1000);
    chk("store write", {31'h0, ev}, 32'h0);
    repeat (300) @(posedge clock);
    apb(0, 8'h20, 32'h0);
    chk("stored total", rv, 32'h0a0002a0);
    run(8'h00, 100, 12800, 12288, 0, 0, 1, 32'h3902, 32'h0e00015e, 3, 4096);
    chk("led steady", {31'h0, led_green_r}, 32'h1);
    apb(1, 8'h00, 32'h0);
    chk("edit in exchange", {31'h0, ev}, 32'h1);
    apb(1, 8'h1c, 32'h0);
    chk("status write", {31'h0, ev}, 32'h1);
    apb(1, 8'h18, 32'h4);
    apb(1, 8'h28, 32'd5);
    chk("store locked", {31'h0, ev}, 32'h1);
    apb(0, 8'h34, 32'h0);
    chk("unmapped", {31'h0, ev}, 32'h1);
    complete_run;
  end
endmodule // encoder_scaling_tb_top
